// ### hw/pin_irq_controller.sv
/*
  External pin interrupt controller with an AXI4-Lite register slave.
  Assumes pins synchronous to aclk and a single master issuing at most
  one write and one read at a time.
*/
// Added by the designer: register access over AXI4-Lite.
// Notes on behaviour
// RULE1: software enables clocks, configures, then enables
// RULE2: filter clock on only after nonmaskable configuration
// RULE3: enable bit switches controller on and off
// RULE4: soft reset clears all registers, disables
// RULE5: sense field picks one of five triggers
// RULE6: matching trigger sets the pin flag
// RULE7: edge mode re-flags only on fresh edge
// RULE8: level mode re-flags at once if matching
// RULE9: filter active only when filter bit set
// RULE10: filter outputs majority of three samples
// RULE11: unfiltered detection needs no filter clock
// RULE12: one flag per pin, write one clears
// RULE13: flag requests interrupt only when enabled
// RULE14: irq high while any enabled flag set
`timescale 1ns/10ps
module pin_irq_controller
  import pin_irq_pkg::*;
#(
  parameter int NUM_PINS   = pin_irq_pkg::NUM_PINS_DEFAULT,
  parameter int FILTER_DIV = pin_irq_pkg::FILTER_DIV_DEFAULT
) (
  // clock and reset
  input  wire logic                aclk,
  input  wire logic                aresetn,
  // write address and data
  input  wire logic                awvalid,
  output      logic                awready,
  input  wire logic [7:0]          awaddr,
  input  wire logic                wvalid,
  output      logic                wready,
  input  wire logic [31:0]         wdata,
  input  wire logic [3:0]          wstrb,
  // write response
  output      logic                bvalid,
  input  wire logic                bready,
  output      logic [1:0]          bresp,
  // read
  input  wire logic                arvalid,
  output      logic                arready,
  input  wire logic [7:0]          araddr,
  output      logic                rvalid,
  input  wire logic                rready,
  output      logic [31:0]         rdata,
  output      logic [1:0]          rresp,
  // external pins and interrupt
  input  wire logic [NUM_PINS-1:0] pins,
  output      logic                irq
);
  import pin_irq_pkg::*;

  localparam int NCFG  = (NUM_PINS + PINS_PER_CFG - 1) / PINS_PER_CFG;
  localparam int DIV_W = $clog2(FILTER_DIV + 1);

  if (NUM_PINS < 1 || NUM_PINS > 32 || FILTER_DIV < 1) begin : g_bad
    $error("pin count must be 1..32 and filter divider at least 1");
  end

  logic [7:0]          aw_addr;
  logic [31:0]         w_data;
  logic [3:0]          w_strb;
  logic                enable;
  logic                fclk_on;
  logic [NUM_PINS-1:0] flags;
  logic [NUM_PINS-1:0] inten;
  logic [NUM_PINS-1:0] next_flags;
  logic [NUM_PINS-1:0] next_inten;
  logic [NUM_PINS-1:0] clr_vec;
  logic [31:0]         cfg [NCFG];
  logic [DIV_W-1:0]    div_cnt;
  logic                tick;
  logic                wr_go;
  logic                do_srst;
  logic [31:0]         wmask;
  logic [31:0]         wval;
  region_t             wr_reg;
  logic [31:0]         rd_word;
  pin_sense_if #(.N(NUM_PINS)) si ();

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  function automatic region_t region_of(input logic [7:0] a);
    if (a[1:0] != 2'h0) begin
      return R_NONE;
    end else if (a == CTRL_OFS) begin
      return R_CTRL;
    end else if (a == IEN_CLR_OFS) begin
      return R_IEN_CLR;
    end else if (a == IEN_SET_OFS) begin
      return R_IEN_SET;
    end else if (a == FLAGS_OFS) begin
      return R_FLAGS;
    end else if (a == LEVEL_OFS) begin
      return R_LEVEL;
    end else if (a >= CFG_BASE_OFS && a < CFG_BASE_OFS + 8'(4 * NCFG)) begin
      return R_CFG;
    end else begin
      return R_NONE;
    end
  endfunction

  function automatic int cfg_idx(input logic [7:0] a);
    return int'((a - CFG_BASE_OFS) >> 2);
  endfunction

  assign wr_reg  = region_of(aw_addr);
  // both halves in and no answer out: true for exactly one cycle
  assign wr_go   = !awready && !wready && !bvalid;
  assign wmask   = strb_mask(w_strb);
  assign wval    = w_data & wmask;
  // a soft reset discards every other effect of the same write
  assign do_srst = wr_go && wr_reg == R_CTRL && wval[CTRL_SRST_BIT]; // RULE4

  // ---------------------------------------------------------------
  // AXI4-Lite write channels
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      wready  <= 1'b1;
      bvalid  <= 1'b0;
      bresp   <= RESP_OKAY;
      aw_addr <= 8'h00;
      w_data  <= REG_RESET;
      w_strb  <= 4'h0;
    end else begin
      if (awvalid && awready) begin
        aw_addr <= awaddr;
        awready <= 1'b0;
      end
      if (wvalid && wready) begin
        w_data <= wdata;
        w_strb <= wstrb;
        wready <= 1'b0;
      end
      if (wr_go) begin
        bvalid <= 1'b1;
        bresp  <= (wr_reg == R_NONE) ? RESP_SLVERR : RESP_OKAY;
      end else if (bvalid && bready) begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite read channels
  // ---------------------------------------------------------------
  always_comb begin
    rd_word = 32'h0000_0000;
    case (region_of(araddr))
      R_CTRL: begin
        rd_word[CTRL_EN_BIT]   = enable;
        rd_word[CTRL_FCLK_BIT] = fclk_on;
      end
      R_IEN_CLR: rd_word[NUM_PINS-1:0] = inten;
      R_IEN_SET: rd_word[NUM_PINS-1:0] = inten;
      R_FLAGS:   rd_word[NUM_PINS-1:0] = flags;
      R_LEVEL:   rd_word[NUM_PINS-1:0] = si.level;
      R_CFG:     rd_word = cfg[cfg_idx(araddr)];
      default:   rd_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= REG_RESET;
      rresp   <= RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= rd_word;
      rresp   <= (region_of(araddr) == R_NONE) ? RESP_SLVERR : RESP_OKAY;
    end else if (rvalid && rready) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // control and pin configuration
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn || do_srst) begin // RULE4
      enable  <= 1'b0;
      fclk_on <= 1'b0;
    end else if (wr_go && wr_reg == R_CTRL) begin
      if (wmask[CTRL_EN_BIT]) begin
        enable <= w_data[CTRL_EN_BIT]; // RULE3
      end
      if (wmask[CTRL_FCLK_BIT]) begin
        fclk_on <= w_data[CTRL_FCLK_BIT];
      end
    end
  end

  always_ff @(posedge aclk) begin
    for (int k = 0; k < NCFG; k++) begin
      if (!aresetn || do_srst) begin
        cfg[k] <= REG_RESET;
      end else if (wr_go && wr_reg == R_CFG && cfg_idx(aw_addr) == k) begin
        cfg[k] <= (cfg[k] & ~wmask) | wval;
      end
    end
  end

  always_comb begin
    si.sense   = '0;
    si.filt_on = '0;
    for (int p = 0; p < NUM_PINS; p++) begin
      si.sense[p] =
        cfg[p / PINS_PER_CFG][(p % PINS_PER_CFG) * CFG_FIELD_W +: 3]; // RULE5
      si.filt_on[p] =
        cfg[p / PINS_PER_CFG][(p % PINS_PER_CFG) * CFG_FIELD_W + CFG_FILT_BIT];
    end
  end

  // ---------------------------------------------------------------
  // filter-rate divider
  // ---------------------------------------------------------------
  // stopping it freezes filtered pins only; unfiltered ones keep working
  always_ff @(posedge aclk) begin
    if (!aresetn || do_srst || !fclk_on) begin
      div_cnt <= '0;
      tick    <= 1'b0;
    end else if (div_cnt == DIV_W'(FILTER_DIV - 1)) begin
      div_cnt <= '0;
      tick    <= 1'b1;
    end else begin
      div_cnt <= div_cnt + 1'b1;
      tick    <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // sense unit
  // ---------------------------------------------------------------
  assign si.pins   = pins;
  assign si.tick   = tick;
  assign si.enable = enable; // RULE3
  assign si.clear  = do_srst;

  pin_sense_unit #(.N(NUM_PINS)) u_sense (
    .aclk    (aclk),
    .aresetn (aresetn),
    .si      (si.unit)
  );

  // ---------------------------------------------------------------
  // flags, enables, interrupt
  // ---------------------------------------------------------------
  // a hit in the cycle of its clear wins, so a held level re-flags
  always_comb begin
    clr_vec    = (wr_go && wr_reg == R_FLAGS) ? wval[NUM_PINS-1:0] : '0;
    next_flags = (flags & ~clr_vec) | si.hit; // RULE6 RULE12
    next_inten = inten;
    if (wr_go && wr_reg == R_IEN_SET) begin
      next_inten = inten | wval[NUM_PINS-1:0];
    end else if (wr_go && wr_reg == R_IEN_CLR) begin
      next_inten = inten & ~wval[NUM_PINS-1:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || do_srst) begin
      flags <= '0;
      inten <= '0;
    end else begin
      flags <= next_flags;
      inten <= next_inten;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || do_srst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(next_flags & next_inten); // RULE13 RULE14
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_flag_sets: assert property ( // RULE6
    |si.hit && !do_srst |=> (flags & $past(si.hit)) == $past(si.hit))
    else $error("hit did not set its flag");
  a_flag_w1c: assert property ( // RULE12
    |clr_vec && !do_srst |=> (flags & $past(clr_vec) & ~$past(si.hit)) == '0)
    else $error("write one did not clear the flag");
  a_irq_enable: assert property ( // RULE13
    wr_go && wr_reg == R_IEN_SET && |(wval[NUM_PINS-1:0] & flags)
    && !do_srst |=> irq)
    else $error("enabled pending flag raised no interrupt");
  a_irq_pair: assert property ( // RULE14
    irq == |(flags & inten))
    else $error("interrupt disagrees with flags and enables");
  a_enable_write: assert property ( // RULE3
    wr_go && wr_reg == R_CTRL && wmask[CTRL_EN_BIT] && !do_srst
    |=> enable == $past(w_data[CTRL_EN_BIT]))
    else $error("enable bit did not follow the write");
  a_soft_reset: assert property ( // RULE4
    do_srst |=> !enable && !fclk_on && flags == '0 && inten == '0 && !irq)
    else $error("soft reset left state behind");

  // with no flag write or soft reset pending, flags only ever gain bits
  a_flag_sticky: assert property ( // RULE12
    !(wr_go && wr_reg == R_FLAGS) && !do_srst
    |=> (flags & $past(flags)) == $past(flags))
    else $error("flag dropped without a clear");
  a_disabled_hold: assert property ( // RULE3
    !enable && !(wr_go && wr_reg == R_FLAGS) && !do_srst
    |=> flags == $past(flags))
    else $error("flags moved while disabled");
  a_enable_gate: assert property ( // RULE3
    !enable |-> si.hit == '0)
    else $error("disabled controller raised a hit");
  a_commit_once: assert property ( // RULE12
    wr_go |=> !wr_go)
    else $error("one write committed twice");
  a_inten_set: assert property ( // RULE13
    wr_go && wr_reg == R_IEN_SET && !do_srst
    |=> (inten & $past(wval[NUM_PINS-1:0])) == $past(wval[NUM_PINS-1:0]))
    else $error("enable set write did not set its bits");
  a_srst_config: assert property ( // RULE4
    do_srst |=> cfg[0] == REG_RESET && div_cnt == '0 && !tick)
    else $error("soft reset left configuration behind");
  a_filter_stop: assert property ( // RULE11
    !fclk_on |=> !tick)
    else $error("filter tick ran with its clock off");

  c_irq_rise:  cover property ($rose(irq));
  c_srst:      cover property (do_srst);
  c_clr_rearm: cover property (|(clr_vec & si.hit));
endmodule

// ### hw/pin_sense_unit.sv
/*
  Per-pin trigger detection with optional majority filter.
  Assumes pins are synchronous to aclk and tick is a one-cycle
  filter-rate enable pulse.
*/
`timescale 1ns/10ps
module pin_sense_unit #(
  parameter int N = 18
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // sense bundle
  pin_sense_if.unit si
);
  import pin_irq_pkg::*;

  logic [N-1:0]      prev_raw;
  logic [N-1:0]      prev_filt;
  logic [N-1:0][2:0] smp;
  logic              tick_d;
  logic [N-1:0]      val;
  logic [N-1:0]      prv;
  logic [N-1:0]      fresh;

  // ---------------------------------------------------------------
  // unfiltered history, every aclk
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn || si.clear) begin
      prev_raw <= '0;
    end else begin
      prev_raw <= si.pins; // RULE11
    end
  end

  // ---------------------------------------------------------------
  // majority filter, sampled only on the filter tick
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn || si.clear) begin
      smp       <= '0;
      prev_filt <= '0;
      tick_d    <= 1'b0;
    end else begin
      tick_d <= si.tick;
      for (int i = 0; i < N; i++) begin
        if (si.tick) begin
          smp[i]       <= {smp[i][1:0], si.pins[i]}; // RULE10
          prev_filt[i] <= maj3(smp[i]);
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // trigger selection
  // ---------------------------------------------------------------
  // a filtered edge is judged only in the cycle after a tick, so one
  // filtered transition yields exactly one hit
  always_comb begin
    val   = '0;
    prv   = '0;
    fresh = '0;
    si.hit   = '0;
    si.level = '0;
    for (int i = 0; i < N; i++) begin
      val[i]   = si.filt_on[i] ? maj3(smp[i]) : si.pins[i]; // RULE9
      prv[i]   = si.filt_on[i] ? prev_filt[i] : prev_raw[i];
      fresh[i] = si.filt_on[i] ? tick_d : 1'b1;
      si.level[i] = val[i];
      case (sense_t'(si.sense[i])) // RULE5
        SENSE_RISE: si.hit[i] = fresh[i] & val[i] & ~prv[i]; // RULE7
        SENSE_FALL: si.hit[i] = fresh[i] & ~val[i] & prv[i];
        SENSE_BOTH: si.hit[i] = fresh[i] & (val[i] ^ prv[i]);
        SENSE_HIGH: si.hit[i] = val[i]; // RULE8
        SENSE_LOW:  si.hit[i] = ~val[i];
        default:    si.hit[i] = 1'b0;
      endcase
      si.hit[i] = si.hit[i] & si.enable;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  for (genvar i = 0; i < N; i++) begin : g_chk
    a_sense_fall: assert property ( // RULE5
      !si.filt_on[i] && si.sense[i] == SENSE_FALL && si.enable
      && $fell(si.pins[i]) |-> si.hit[i])
      else $error("falling edge did not trigger");
    a_edge_static: assert property ( // RULE7
      !si.filt_on[i] && si.sense[i] == SENSE_RISE && si.enable
      && $stable(si.pins[i]) && !si.clear |-> !si.hit[i])
      else $error("static level re-raised an edge trigger");
    a_level_rearm: assert property ( // RULE8
      !si.filt_on[i] && si.sense[i] == SENSE_HIGH && si.enable
      && si.pins[i] |-> si.hit[i])
      else $error("matching high level gave no hit");
    a_filter_gate: assert property ( // RULE9
      si.filt_on[i] && si.sense[i] == SENSE_HIGH && si.enable
      && smp[i] == 3'h0 |-> !si.hit[i])
      else $error("filtered pin bypassed the filter");
    a_filter_majority: assert property ( // RULE10
      si.filt_on[i] && si.sense[i] == SENSE_HIGH && si.enable
      |-> si.hit[i] == ($countones(smp[i]) >= 2))
      else $error("filter output is not the majority");
    a_filter_bypass: assert property ( // RULE11
      !si.filt_on[i] && si.sense[i] == SENSE_LOW && si.enable
      |-> si.hit[i] == !si.pins[i])
      else $error("unfiltered level hit waits on the filter");
  end

  c_filtered_edge: cover property (si.filt_on[0] && si.hit[0] && tick_d);
  c_level_rearm:   cover property ((si.sense[0] == SENSE_HIGH && si.hit[0]) [*3]);
endmodule

// ### inc/pin_irq_pkg.sv
/*
  Shared constants, types and helper functions of the external pin
  interrupt controller. Assumes a 32-bit AXI4-Lite register bus.
*/
package pin_irq_pkg;

  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS     = 8'h00;
  localparam logic [7:0] IEN_CLR_OFS  = 8'h08;
  localparam logic [7:0] IEN_SET_OFS  = 8'h0c;
  localparam logic [7:0] FLAGS_OFS    = 8'h10;
  localparam logic [7:0] LEVEL_OFS    = 8'h14;
  localparam logic [7:0] CFG_BASE_OFS = 8'h18;

  // ---------------------------------------------------------------
  // field positions, reset values, defaults
  // ---------------------------------------------------------------
  localparam int CTRL_SRST_BIT = 0;
  localparam int CTRL_EN_BIT   = 1;
  localparam int CTRL_FCLK_BIT = 2;
  localparam int CFG_FILT_BIT  = 3;
  localparam int CFG_FIELD_W   = 4;
  localparam int PINS_PER_CFG  = 8;
  localparam logic [31:0] REG_RESET = 32'h0000_0000;
  localparam int NUM_PINS_DEFAULT   = 18;
  localparam int FILTER_DIV_DEFAULT = 4;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    SENSE_NONE, SENSE_RISE, SENSE_FALL, SENSE_BOTH, SENSE_HIGH, SENSE_LOW
  } sense_t;

  typedef enum {
    R_CTRL, R_IEN_CLR, R_IEN_SET, R_FLAGS, R_LEVEL, R_CFG, R_NONE
  } region_t;

  // majority of three samples
  function automatic logic maj3(input logic [2:0] s);
    return (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction

  // byte strobes to a bit mask
  function automatic logic [31:0] strb_mask(input logic [3:0] strb);
    logic [31:0] m;
    m = 32'h0000_0000;
    for (int b = 0; b < 4; b++) begin
      m[b*8 +: 8] = {8{strb[b]}};
    end
    return m;
  endfunction

endpackage

// ### inc/pin_sense_if.sv
/*
  Bundle between the register side of the pin interrupt controller
  and its per-pin sense unit. Assumes both ends run on one clock.
*/
`timescale 1ns/10ps
interface pin_sense_if #(parameter int N = 18);
  logic [N-1:0]      pins;
  logic [N-1:0]      filt_on;
  logic [N-1:0][2:0] sense;
  logic              tick;
  logic              enable;
  logic              clear;
  logic [N-1:0]      hit;
  logic [N-1:0]      level;

  modport ctrl (output pins, filt_on, sense, tick, enable, clear,
                input  hit, level);
  modport unit (input  pins, filt_on, sense, tick, enable, clear,
                output hit, level);
endinterface

// ### verif/pin_source.sv
/*
  Board-side model of the external pins of the pin interrupt controller.
  Assumes callers sit just after a rising edge of aclk.
*/
`timescale 1ns/10ps
module pin_source #(
  parameter int N = 18
) (
  // external pins
  output logic [N-1:0] pins
);
  // ---------------------------------------------------------------
  // pin levels
  // ---------------------------------------------------------------
  initial pins = '0;

  // levels change only after an edge, so the dut never sees a race
  task automatic put(input logic [N-1:0] v);
    pins <= v;
  endtask
endmodule

// ### verif/tb.sv
/*
  Self-checking bench of the pin interrupt controller.
  Assumes an AXI4-Lite master here and the pin model beside the dut.
*/
`timescale 1ns/10ps
`define CHK(got, exp) begin \
  samples_checked++; \
  if ((got) !== (exp)) begin \
    miscompares++; \
    $display("[FAIL] %0t got %h exp %h", $time, got, exp); \
  end \
end
module tb;
  import pin_irq_pkg::*;
  localparam int NP = 18;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, irq;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic [NP-1:0] pins;
  int          miscompares = 0;
  int          samples_checked = 0;

  // ---------------------------------------------------------------
  // clock, dut, pin model
  // ---------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  // default divider, so a pulse no longer than one tick period is really rejected
  pin_irq_controller dut (
    .aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata,
    .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid,
    .rready, .rdata, .rresp, .pins, .irq
  );

  pin_source pin_src (.pins(pins));

  // ---------------------------------------------------------------
  // bus tasks; handshakes sampled at the falling edge before the
  // rising edge that moves them, since nothing changes in between
  // ---------------------------------------------------------------
  task automatic close_out();
    if (miscompares == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic hang();
    miscompares++;
    $display("[FAIL] %0t bus wait ran out", $time);
    close_out();
  endtask

  // bready and rready stay high between transfers, so no strobe drops and
  // rises again in one time step
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er,
                    input logic [3:0] st = 4'hf);
    logic ta, tw, done;
    done = 1'b0;
    awaddr <= a;
    wdata <= d;
    wstrb <= st;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 40 && !done; n++) begin
      @(negedge aclk);
      ta = awvalid & awready;
      tw = wvalid & wready;
      if (bvalid & bready) begin
        `CHK(bresp, er)
        done = 1'b1;
      end
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    if (!done) hang();
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ta, done;
    done = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 40 && !done; n++) begin
      @(negedge aclk);
      ta = arvalid & arready;
      if (rvalid & rready) begin
        `CHK(rdata, ed)
        `CHK(rresp, er)
        done = 1'b1;
      end
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
    end
    if (!done) hang();
  endtask

  task automatic chk_irq(input logic e);
    @(negedge aclk);
    `CHK(irq, e)
    @(posedge aclk);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0000_0000;
    wstrb = 4'h0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(CTRL_OFS, 32'h0, RESP_OKAY);
    rd(FLAGS_OFS, 32'h0, RESP_OKAY);
    rd(IEN_SET_OFS, 32'h0, RESP_OKAY);
    rd(CFG_BASE_OFS, 32'h0, RESP_OKAY);
    rd(8'h40, 32'h0, RESP_SLVERR);
    wr(8'h40, 32'hffff_ffff, RESP_SLVERR);
    wr(LEVEL_OFS, 32'hffff_ffff, RESP_OKAY);
    rd(LEVEL_OFS, 32'h0, RESP_OKAY);
    // configure first, enable last; pin4 low-level matches at once
    wr(CFG_BASE_OFS, 32'h0005_4321, RESP_OKAY);
    wr(CFG_BASE_OFS + 8'h08, 32'h0000_0010, RESP_OKAY);
    wr(CTRL_OFS, 32'h2, RESP_OKAY);
    idle(2);
    rd(FLAGS_OFS, 32'h10, RESP_OKAY);
    chk_irq(1'b0);
    wr(IEN_SET_OFS, 32'h10, RESP_OKAY);
    chk_irq(1'b1);
    wr(FLAGS_OFS, 32'h10, RESP_OKAY);
    rd(FLAGS_OFS, 32'h10, RESP_OKAY);
    pin_src.put(18'h0_0010);
    idle(1);
    wr(FLAGS_OFS, 32'h10, RESP_OKAY);
    rd(FLAGS_OFS, 32'h0, RESP_OKAY);
    chk_irq(1'b0);
    // flags on 0,2,3,17; pin3 is high-level, pin1 waits for a fall
    pin_src.put(18'h2_001f);
    idle(2);
    rd(FLAGS_OFS, 32'h2_000d, RESP_OKAY);
    wr(FLAGS_OFS, 32'h0, RESP_OKAY);
    rd(FLAGS_OFS, 32'h2_000d, RESP_OKAY);
    wr(FLAGS_OFS, 32'h3_ffff, RESP_OKAY);
    idle(3);
    rd(FLAGS_OFS, 32'h8, RESP_OKAY);
    pin_src.put(18'h0_0010);
    idle(2);
    rd(FLAGS_OFS, 32'he, RESP_OKAY);
    wr(FLAGS_OFS, 32'hf, RESP_OKAY);
    rd(FLAGS_OFS, 32'h0, RESP_OKAY);
    // disabled: edges and levels are ignored, flags hold
    wr(CTRL_OFS, 32'h0, RESP_OKAY);
    pin_src.put(18'h2_0001);
    idle(2);
    rd(FLAGS_OFS, 32'h0, RESP_OKAY);
    wr(CTRL_OFS, 32'h2, RESP_OKAY);
    idle(2);
    rd(FLAGS_OFS, 32'h10, RESP_OKAY);
    chk_irq(1'b1);
    wr(IEN_CLR_OFS, 32'h10, RESP_OKAY);
    rd(IEN_SET_OFS, 32'h0, RESP_OKAY);
    chk_irq(1'b0);
    // pin5 filtered rise, pin6 plain rise; filter clock after config
    wr(CFG_BASE_OFS, 32'h0190_0321, RESP_OKAY);
    wr(CTRL_OFS, 32'h6, RESP_OKAY);
    wr(FLAGS_OFS, 32'h3_ffff, RESP_OKAY);
    rd(FLAGS_OFS, 32'h0, RESP_OKAY);
    // three cycles span at most one filter tick: no filtered edge
    pin_src.put(18'h2_0061);
    idle(3);
    pin_src.put(18'h2_0001);
    idle(4);
    rd(FLAGS_OFS, 32'h40, RESP_OKAY);
    rd(LEVEL_OFS, 32'h2_0001, RESP_OKAY);
    pin_src.put(18'h2_0021);
    idle(10);
    pin_src.put(18'h2_0001);
    idle(4);
    rd(FLAGS_OFS, 32'h60, RESP_OKAY);
    // only byte 1 is strobed: pins 2 and 3 change, the rest stand
    wr(CFG_BASE_OFS, 32'hffff_ffff, RESP_OKAY, 4'h2);
    rd(CFG_BASE_OFS, 32'h0190_ff21, RESP_OKAY);
    // soft reset wipes everything and drops the request
    wr(IEN_SET_OFS, 32'h20, RESP_OKAY);
    chk_irq(1'b1);
    wr(CTRL_OFS, 32'h3, RESP_OKAY);
    chk_irq(1'b0);
    rd(CTRL_OFS, 32'h0, RESP_OKAY);
    rd(FLAGS_OFS, 32'h0, RESP_OKAY);
    rd(IEN_SET_OFS, 32'h0, RESP_OKAY);
    rd(CFG_BASE_OFS, 32'h0, RESP_OKAY);
    close_out();
  end
endmodule
